// [design/lane_decode.sv]
`timescale 1ns/100ps
`include "sram_host_defs.svh"
module lane_decode (
  lane_if.decoder lanes
);
  // Active-high lane mask; the top inverts it into the low-active strobes
  always_comb begin
    case (lanes.width)
      `WIDTH_SEL_X32: lanes.lane_mask = `LANE_ALL;
      `WIDTH_SEL_X16: lanes.lane_mask = lanes.byte_offset[1] ? 4'hc : 4'h3;
      `WIDTH_SEL_X8: lanes.lane_mask = 4'h1 << lanes.byte_offset;
      default: lanes.lane_mask = `LANE_ALL;
    endcase
  end
endmodule // lane_decode

// [design/lane_if.sv]
`timescale 1ns/100ps
interface lane_if;
  logic [1:0] width;
  logic [1:0] byte_offset;
  logic [3:0] lane_mask;
  modport decoder (
    input width,
    input byte_offset,
    output lane_mask
  );
  modport user (
    output width,
    output byte_offset,
    input lane_mask
  );
endinterface // lane_if

// [design/sram_host.sv]
`timescale 1ns/100ps
`include "sram_host_defs.svh"
module sram_host #(
  parameter int ACCESS_CYCLES = `ACCESS_CYCLES,
  parameter int SETUP_CYCLES = `SETUP_CYCLES,
  parameter int IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_width,
  input wire logic req_fetch,
  input wire logic [`ADDR_WIDTH-1:0] req_addr,
  input wire logic [`DATA_WIDTH-1:0] req_wdata,
  input wire logic die_select_follow,
  input wire logic single_strobe_mode,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`DATA_WIDTH-1:0] rsp_rdata,
  output logic [`ADDR_WIDTH-1:0] mem_addr,
  output logic external_access_strobe_n,
  output logic [`LANES-1:0] lane_select_n,
  output logic [1:0] die_select_n,
  output logic write_control_n,
  output logic output_gate_n,
  input wire logic [`DATA_WIDTH-1:0] module_data_lines_i,
  output logic [`DATA_WIDTH-1:0] module_data_lines_o,
  output logic [`DATA_WIDTH-1:0] module_data_lines_oe_n
);
  typedef struct packed {
    sram_host_pkg::phase_t phase;
    logic [`CNT_WIDTH-1:0] cnt;
    logic write;
    logic [1:0] width;
    logic [`ADDR_WIDTH-1:0] addr;
    logic [`DATA_WIDTH-1:0] wdata;
    logic [`DATA_WIDTH-1:0] rdata;
    logic [`DATA_WIDTH-1:0] pin_meta;
    logic [`DATA_WIDTH-1:0] pin_sync;
    logic ready;
    logic rsp;
    logic strobe_n;
    logic [`LANES-1:0] lane_n;
    logic [1:0] die_n;
    logic wr_n;
    logic [`DATA_WIDTH-1:0] oe_n;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  lane_if lanes ();

  lane_decode u_lane_decode (
    .lanes(lanes.decoder)
  );

  // Fetches never narrower than 16 bits; single-strobe hosts only do full words
  function automatic logic [1:0] legal_width(input logic [1:0] w, input logic fetch,
                                             input logic single);
    if (single) legal_width = `WIDTH_SEL_X32;
    else if (fetch && w == `WIDTH_SEL_X8) legal_width = `WIDTH_SEL_X16;
    else if (w > `WIDTH_SEL_X8) legal_width = `WIDTH_SEL_X32;
    else legal_width = w;
  endfunction

  assign lanes.width = cur_ff.width;
  assign lanes.byte_offset = cur_ff.addr[1:0];

  always_comb begin
    logic [`DATA_WIDTH-1:0] lane_bits;
    lane_bits = '0;
    nxt_cur = cur_ff;
    nxt_cur.pin_meta = module_data_lines_i;
    nxt_cur.pin_sync = cur_ff.pin_meta;
    nxt_cur.rsp = 1'b0;
    for (int i = 0; i < `LANES; i++) begin
      lane_bits[i*8 +: 8] = {8{lanes.lane_mask[i]}};
    end
    case (cur_ff.phase)
      sram_host_pkg::ST_IDLE: begin
        nxt_cur.ready = 1'b1;
        if (req_valid && cur_ff.ready) begin
          nxt_cur.ready = 1'b0;
          nxt_cur.write = req_write;
          nxt_cur.width = legal_width(req_width, req_fetch, single_strobe_mode);
          nxt_cur.addr = req_addr;
          nxt_cur.wdata = req_wdata;
          nxt_cur.wr_n = ~req_write;
          nxt_cur.cnt = SETUP_CYCLES[`CNT_WIDTH-1:0];
          nxt_cur.phase = sram_host_pkg::ST_SETUP;
        end
      end
      sram_host_pkg::ST_SETUP: begin
        // Address and write control settle before the strobe falls
        if (cur_ff.cnt <= `CNT_WIDTH'(1)) begin
          nxt_cur.strobe_n = 1'b0;
          if (single_strobe_mode) nxt_cur.lane_n = 4'h0;
          else nxt_cur.lane_n = ~lanes.lane_mask;
          // Die selects follow the strobe or sit low for constant power
          nxt_cur.die_n = 2'b00;
          if (cur_ff.write) nxt_cur.oe_n = ~lane_bits;
          nxt_cur.cnt = ACCESS_CYCLES[`CNT_WIDTH-1:0];
          nxt_cur.phase = sram_host_pkg::ST_ACCESS;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CNT_WIDTH'(1);
        end
      end
      sram_host_pkg::ST_ACCESS: begin
        // Device is asynchronous: only our own count paces the access
        if (cur_ff.cnt <= `CNT_WIDTH'(1)) begin
          nxt_cur.phase = sram_host_pkg::ST_DONE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CNT_WIDTH'(1);
        end
      end
      sram_host_pkg::ST_DONE: begin
        // Sampled data already passed two flops while the strobe was low
        nxt_cur.rdata = cur_ff.write ? '0 : (cur_ff.pin_sync & lane_bits);
        nxt_cur.rsp = 1'b1;
        nxt_cur.strobe_n = 1'b1;
        nxt_cur.lane_n = `LANE_ALL;
        nxt_cur.die_n = die_select_follow ? 2'b11 : 2'b00;
        nxt_cur.oe_n = '1;
        nxt_cur.wr_n = 1'b1;
        nxt_cur.cnt = IDLE_CYCLES[`CNT_WIDTH-1:0];
        nxt_cur.phase = sram_host_pkg::ST_GAP;
      end
      sram_host_pkg::ST_GAP: begin
        if (cur_ff.cnt <= `CNT_WIDTH'(1)) begin
          nxt_cur.ready = 1'b1;
          nxt_cur.phase = sram_host_pkg::ST_IDLE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `CNT_WIDTH'(1);
        end
      end
      default: begin
        nxt_cur.phase = sram_host_pkg::ST_IDLE;
      end
    endcase
    // Tied-low die selects leave standby on the first clock after reset; kept that way even when idle
    if (!die_select_follow) nxt_cur.die_n = 2'b00;
    else if (nxt_cur.strobe_n) nxt_cur.die_n = 2'b11;
  end

  // Access wait must fit the read path of two sync flops plus one sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '{phase: sram_host_pkg::ST_IDLE, cnt: '0, write: 1'b0, width: 2'h0,
                  addr: '0, wdata: '0, rdata: '0, pin_meta: '0, pin_sync: '0,
                  ready: 1'b0, rsp: 1'b0, strobe_n: 1'b1, lane_n: 4'hf, die_n: 2'h3,
                  wr_n: 1'b1, oe_n: '1};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign req_ready = cur_ff.ready;
  assign rsp_valid = cur_ff.rsp;
  assign rsp_rdata = cur_ff.rdata;
  assign mem_addr = cur_ff.addr;
  assign external_access_strobe_n = cur_ff.strobe_n;
  assign lane_select_n = cur_ff.lane_n;
  assign die_select_n = cur_ff.die_n;
  assign write_control_n = cur_ff.wr_n;
  assign output_gate_n = 1'b0;
  assign module_data_lines_o = cur_ff.wdata;
  assign module_data_lines_oe_n = cur_ff.oe_n;
endmodule // sram_host

// [design/sram_host_defs.svh]
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

// Timing counts at 200 MHz (5 ns period)
`define CLK_PERIOD_PS 5000
`define ACCESS_TIME_PS 25000
`define ACCESS_CYCLES ((`ACCESS_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_TIME_PS 5000
`define SETUP_CYCLES ((`SETUP_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define IDLE_TIME_PS 5000
`define IDLE_CYCLES ((`IDLE_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ADDR_WIDTH 24
`define DATA_WIDTH 32
`define LANES 4
`define CNT_WIDTH 8
`define LANE_ALL 4'hf
`define WIDTH_SEL_X32 2'h0
`define WIDTH_SEL_X16 2'h1
`define WIDTH_SEL_X8 2'h2

`endif

// [design/sram_host_pkg.sv]
package sram_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACCESS = 3'b010,
    ST_DONE = 3'b011,
    ST_GAP = 3'b100
  } phase_t;

  typedef enum logic [1:0] {
    WIDTH_X32 = 2'b00,
    WIDTH_X16 = 2'b01,
    WIDTH_X8 = 2'b10
  } width_t;
endpackage

// [dv/sram_host_bench.sv]
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module sram_host_bench;
  logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, req_fetch = 0;
  logic die_select_follow = 1, single_strobe_mode = 0, req_ready, rsp_valid;
  logic [1:0] req_width = 0, die_select_n;
  logic [23:0] req_addr = 0, mem_addr;
  logic [31:0] req_wdata = 0, rsp_rdata, module_data_lines_i, module_data_lines_o;
  logic [31:0] module_data_lines_oe_n, model_q;
  logic [3:0] lane_select_n;
  logic external_access_strobe_n, write_control_n, output_gate_n;
  int fail_count = 0, total_checks = 0;
  sram_host u_dut (.*);
  sram_module_model u_mem (.*);
  // Pin settle delay: the model must not store a released bus while the selects still rise
  assign #1 module_data_lines_i = (module_data_lines_o & ~module_data_lines_oe_n)
    | (model_q & module_data_lines_oe_n);
  always #2.5 clk = ~clk;
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [1:0] wd, input logic f, input logic [23:0] a,
    input logic [31:0] d, exp, input logic [3:0] el);
    logic [3:0] seen;
    seen = 4'hf;
    repeat (20) if (req_ready !== 1'b1) @(negedge clk);
    {req_valid, req_write, req_width, req_fetch, req_addr, req_wdata} = {1'b1, w, wd, f, a, d};
    @(negedge clk);
    req_valid = 1'b0;
    repeat (20) if (rsp_valid !== 1'b1) begin
      seen &= lane_select_n;
      @(negedge clk);
    end
    `CHK("rdata", exp, rsp_rdata)
    `CHK("lanes", el, seen)
  endtask
  task automatic t_word;
    acc(1, 2'h0, 0, 24'h10, 32'hcafe0123, 32'h0, 4'h0);
    acc(0, 2'h0, 0, 24'h10, 32'h0, 32'hcafe0123, 4'h0);
    `CHK("die", 2'h3, die_select_n)
  endtask
  task automatic t_bytes;
    for (int i = 0; i < 4; i++) begin
      acc(1, 2'h2, 0, {22'h8, i[1:0]}, 32'h11223344, 32'h0, ~(4'h1 << i));
    end
    acc(0, 2'h0, 0, 24'h20, 32'h0, 32'h11223344, 4'h0);
    acc(0, 2'h2, 0, 24'h22, 32'h0, 32'h00220000, 4'hb);
  endtask
  task automatic t_half;
    acc(1, 2'h1, 0, 24'h32, 32'ha5a55a5a, 32'h0, 4'h3);
    acc(0, 2'h1, 0, 24'h32, 32'h0, 32'ha5a50000, 4'h3);
    acc(0, 2'h2, 1, 24'h33, 32'h0, 32'ha5a50000, 4'h3);
  endtask
  task automatic t_single;
    single_strobe_mode = 1'b1;
    acc(1, 2'h2, 0, 24'h40, 32'h89abcdef, 32'h0, 4'h0);
    acc(0, 2'h2, 0, 24'h41, 32'h0, 32'h89abcdef, 4'h0);
    single_strobe_mode = 1'b0;
  endtask
  task automatic t_tied;
    die_select_follow = 1'b0;
    acc(0, 2'h0, 0, 24'h10, 32'h0, 32'hcafe0123, 4'h0);
    `CHK("die", 2'h0, die_select_n)
    die_select_follow = 1'b1;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    t_word();
    t_bytes();
    t_half();
    t_single();
    t_tied();
    report_and_stop();
  end
  // About 14 accesses of nine cycles each; generous margin
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule // sram_host_bench

// [dv/sram_host_monitor.sv]
`timescale 1ns/100ps
module sram_host_monitor #(
  parameter int ACCESS_CYCLES = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic die_select_follow,
  input wire logic single_strobe_mode,
  input wire logic external_access_strobe_n,
  input wire logic [3:0] lane_select_n,
  input wire logic [1:0] die_select_n,
  input wire logic write_control_n,
  input wire logic output_gate_n,
  input wire logic [31:0] module_data_lines_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] low_ff;
  logic [31:0] lane_bits;
  assign lane_bits = {{8{lane_select_n[3]}}, {8{lane_select_n[2]}},
    {8{lane_select_n[1]}}, {8{lane_select_n[0]}}};
  // Counts strobe-low cycles so the access length can be judged without long repetition
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_ff <= 8'h0;
    else low_ff <= external_access_strobe_n ? 8'h0 : low_ff + 8'h1;
  end
  gate_held_a: assert property (output_gate_n == 1'b0)
    else $error("output gate not held low");
  idle_float_a: assert property (external_access_strobe_n |-> &module_data_lines_oe_n)
    else $error("data driven while strobe high");
  read_float_a: assert property (write_control_n |-> &module_data_lines_oe_n)
    else $error("data driven during a read");
  lane_drive_a: assert property ((~module_data_lines_oe_n & lane_bits) == 32'h0)
    else $error("data driven on a disabled lane");
  idle_lanes_a: assert property (external_access_strobe_n |-> lane_select_n == 4'hf)
    else $error("lane select low while idle");
  single_lanes_a: assert property (single_strobe_mode && !external_access_strobe_n
    |-> lane_select_n == 4'h0)
    else $error("lanes split in single strobe mode");
  die_follow_a: assert property (die_select_follow && $stable(die_select_follow)
    |-> die_select_n == {2{external_access_strobe_n}})
    else $error("die selects not following strobe");
  die_tied_a: assert property (!die_select_follow && $stable(die_select_follow)
    && $past(reset_n) |-> die_select_n == 2'h0)
    else $error("die selects not held low");
  // Strobe stays low through the whole access count and the closing done cycle
  access_len_a: assert property ($rose(external_access_strobe_n)
    |-> low_ff == ACCESS_CYCLES + 1)
    else $error("access length wrong");
  write_steady_a: assert property (!external_access_strobe_n |-> $stable(write_control_n))
    else $error("write control moved in access");
  cover property ($fell(external_access_strobe_n) && !write_control_n);
  cover property ($fell(external_access_strobe_n) && write_control_n);
  cover property (!external_access_strobe_n && single_strobe_mode);
  cover property (!external_access_strobe_n && !die_select_follow);
endmodule // sram_host_monitor

bind sram_host sram_host_monitor #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_mon (
  .clk(clk),
  .reset_n(reset_n),
  .die_select_follow(die_select_follow),
  .single_strobe_mode(single_strobe_mode),
  .external_access_strobe_n(external_access_strobe_n),
  .lane_select_n(lane_select_n),
  .die_select_n(die_select_n),
  .write_control_n(write_control_n),
  .output_gate_n(output_gate_n),
  .module_data_lines_oe_n(module_data_lines_oe_n)
);

// [dv/sram_module_model.sv]
`timescale 1ns/100ps
module sram_module_model (
  input wire logic [3:0] lane_select_n,
  input wire logic [1:0] die_select_n,
  input wire logic write_control_n,
  input wire logic output_gate_n,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] module_data_lines_i,
  output logic [31:0] model_q
);
  // No clock: enable and write levels alone pace it
  logic [31:0] mem [0:255];
  logic [3:0] on;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      on[i] = !lane_select_n[i] && !die_select_n[i/2];
      if (on[i] && !write_control_n) mem[mem_addr[9:2]][8*i+:8] = module_data_lines_i[8*i+:8];
      // Floated lanes show inverted garbage, never the stored byte
      model_q[8*i+:8] = mem[mem_addr[9:2]][8*i+:8]
        ^ {8{!(on[i] && write_control_n && !output_gate_n)}};
    end
  end
endmodule // sram_module_model
